// ---- src/ptf_defs.svh ----
// ptf_defs.svh: offsets, field positions, reset values and header constants of the framer
// assumes inclusion by bare name from the framer sources
`ifndef PTF_DEFS_SVH
`define PTF_DEFS_SVH
// register byte offsets
`define PTF_OFS_CTRL 12'h000
`define PTF_OFS_SECONDS 12'h004
`define PTF_OFS_NANOS 12'h008
`define PTF_OFS_LENGTH 12'h00c
`define PTF_OFS_MTU 12'h010
`define PTF_OFS_STATUS 12'h014
`define PTF_OFS_SEQ 12'h018
`define PTF_OFS_DATA 12'h01c
// ctrl fields
`define PTF_CTRL_START 0
`define PTF_CTRL_TIMING 1
`define PTF_CTRL_SIGN 2
`define PTF_CTRL_PAD 3
// reset values
`define PTF_MTU_RST 16'h05dc
// header and check word constants
`define PTF_RTP_VERSION 2'h2
`define PTF_PT_PRE 7'h4d
`define PTF_PT_TIMING 7'h4c
`define PTF_MCAST_ADDR 32'hef003330
`define PTF_PORT_PRE 16'h7570
`define PTF_PORT_TIMING 16'h7571
`define PTF_HDR_BYTES 16'h0028
`define PTF_RTP_AT 16'h001c
`define PTF_EXT_BYTES 16'h0008
`define PTF_CRC_INIT 16'hffff
`define PTF_CRC_POLY 16'h1021
`endif

// ---- src/ptf_framer.sv ----
// ptf_framer.sv: frames preamble and timing-and-management payloads into rtp packets
// assumes one ahb-lite master, single word transfers, and a byte sink with ready
//
// Our own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ptf_defs.svh"
module ptf_framer #(
	parameter int MAX_BYTES = 4096
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic clk_en,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic [7:0] pkt_byte,
	output logic pkt_valid,
	output logic pkt_first,
	output logic pkt_last,
	input wire logic pkt_ready,
	output logic [31:0] pkt_dst_addr,
	output logic [15:0] pkt_dst_port
);
	import ptf_pkg::*;
	localparam int AW = $clog2(MAX_BYTES);

	// ************************************************************
	// bus slave
	// ************************************************************
	logic [11:0] aaddr_r;
	logic awr_r;
	logic asel_r;
	logic [3:0] ctrl_r;
	ptf_word_t sec_r, nano_r;
	logic [15:0] len_r, mtu_r, seq_pre_r, seq_tim_r;
	logic [7:0] mem_r [MAX_BYTES];
	logic [AW-1:0] wptr_r;
	ptf_state_e st_r, st_nxt;
	logic busy;
	wire take = hsel && hready && htrans[1];
	wire wr_go = asel_r && awr_r && clk_en;
	wire wr_ctrl = wr_go && aaddr_r == `PTF_OFS_CTRL;
	wire wr_data = wr_go && aaddr_r == `PTF_OFS_DATA;
	// a start while a set is in flight is ignored so one set keeps one timestamp
	// framing begins at once, so how early a set leaves is up to software
	wire start = wr_ctrl && hwdata[`PTF_CTRL_START] && !busy;
	assign busy = st_r != PTF_IDLE;
	wire [15:0] seq_cur = ctrl_r[`PTF_CTRL_TIMING] ? seq_tim_r : seq_pre_r;
	wire [31:0] rd_mux =
		aaddr_r == `PTF_OFS_CTRL ? {28'h0000000, ctrl_r} :
		aaddr_r == `PTF_OFS_SECONDS ? sec_r :
		aaddr_r == `PTF_OFS_NANOS ? nano_r :
		aaddr_r == `PTF_OFS_LENGTH ? {16'h0000, len_r} :
		aaddr_r == `PTF_OFS_MTU ? {16'h0000, mtu_r} :
		aaddr_r == `PTF_OFS_STATUS ? {30'h00000000, st_r} :
		aaddr_r == `PTF_OFS_SEQ ? {seq_tim_r, seq_pre_r} : 32'h00000000;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			aaddr_r <= 12'h000;
			awr_r <= 1'b0;
			asel_r <= 1'b0;
			hrdata <= 32'h00000000;
			hresp <= 1'b0;
		end else if (clk_en) begin
			asel_r <= take;
			if (take) begin
				aaddr_r <= haddr[11:0];
				awr_r <= hwrite;
			end
			if (asel_r && !awr_r)
				hrdata <= rd_mux;
		end
	end

	// read data are registered, so a read answers one cycle late with a wait state
	wire rd_pend = take && !hwrite;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hreadyout <= 1'b1;
		else if (clk_en)
			hreadyout <= !rd_pend;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_r <= 4'h0;
			sec_r <= 32'h00000000;
			nano_r <= 32'h00000000;
			len_r <= 16'h0000;
			mtu_r <= `PTF_MTU_RST;
			wptr_r <= '0;
		end else if (wr_go && !busy) begin
			case (aaddr_r)
				`PTF_OFS_CTRL: begin
					ctrl_r <= {hwdata[3:1], 1'b0};
					wptr_r <= '0;
				end
				`PTF_OFS_SECONDS: sec_r <= hwdata;
				`PTF_OFS_NANOS: nano_r <= hwdata;
				`PTF_OFS_LENGTH: len_r <= hwdata[15:0];
				`PTF_OFS_MTU: mtu_r <= hwdata[15:0];
				`PTF_OFS_DATA: wptr_r <= wptr_r + AW'(1);
				default: ;
			endcase
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < MAX_BYTES; gi++) begin : g_mem
			always_ff @(posedge hclk) begin
				if (wr_data && !busy && wptr_r == AW'(gi))
					mem_r[gi] <= hwdata[7:0];
			end
		end
	endgenerate

	// ************************************************************
	// packet header and payload sequencing
	// ************************************************************
	// payload = 2 length bytes + len_r structure bytes + 2 check bytes
	logic [15:0] pos_r, hidx_r, room_r, crc_r;
	logic [15:0] seg_r;
	logic mark_r;
	wire [15:0] total = len_r + 16'h0004;
	wire sign = ctrl_r[`PTF_CTRL_SIGN];
	wire timing = ctrl_r[`PTF_CTRL_TIMING];
	wire [15:0] hdr_len = `PTF_HDR_BYTES + (sign ? `PTF_EXT_BYTES : 16'h0000);
	wire [15:0] cap = mtu_r - hdr_len;
	// third to twelfth bit from the top of the nanoseconds word
	wire [31:0] tstamp = {sec_r[21:0], nano_r[29:20]};
	wire pad_bit = timing ? 1'b0 : ctrl_r[`PTF_CTRL_PAD];
	wire [7:0] hb0 = {`PTF_RTP_VERSION, pad_bit, sign, 4'h0};
	wire [7:0] hb1 = {mark_r, timing ? `PTF_PT_TIMING : `PTF_PT_PRE};
	// header bytes after the ip/udp part; ssrc zero, extension follows it
	wire [4:0] rtp_i = 5'(hidx_r - `PTF_RTP_AT);
	wire [7:0] rtp_b =
		rtp_i == 5'd0 ? hb0 : rtp_i == 5'd1 ? hb1 :
		rtp_i == 5'd2 ? seq_cur[15:8] : rtp_i == 5'd3 ? seq_cur[7:0] :
		rtp_i == 5'd4 ? tstamp[31:24] : rtp_i == 5'd5 ? tstamp[23:16] :
		rtp_i == 5'd6 ? tstamp[15:8] : rtp_i == 5'd7 ? tstamp[7:0] :
		8'h00;
	wire [7:0] hdr_b = hidx_r < `PTF_RTP_AT ? 8'h00 : rtp_b;
	wire [15:0] sidx = pos_r - 16'h0002;
	wire [7:0] body_b = pos_r == 16'h0000 ? len_r[15:8] :
		pos_r == 16'h0001 ? len_r[7:0] : mem_r[sidx[AW-1:0]];
	wire [7:0] out_b = st_r == PTF_HDR ? hdr_b :
		st_r == PTF_CRC ? (pos_r == total - 16'h0002 ? crc_r[15:8] : crc_r[7:0]) : body_b;
	// a byte moves into the output register whenever that register is empty or drained;
	// stepping on acceptance instead would send the byte under the index twice
	wire fire = clk_en && (!pkt_valid || pkt_ready) && st_r != PTF_IDLE;
	wire seg_end = room_r == 16'h0001 || pos_r == total - 16'h0001;

	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c;
		for (int i = 7; i >= 0; i--)
			r = (r[15] ^ d[i]) ? ((r << 1) ^ `PTF_CRC_POLY) : (r << 1);
		return r;
	endfunction

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			PTF_IDLE: if (start) st_nxt = PTF_HDR;
			PTF_HDR: if (fire && hidx_r == hdr_len - 16'h0001)
				st_nxt = pos_r >= total - 16'h0002 ? PTF_CRC : PTF_BODY;
			PTF_BODY: if (fire) begin
				if (seg_end) st_nxt = PTF_HDR;
				else if (pos_r == total - 16'h0003) st_nxt = PTF_CRC;
			end
			PTF_CRC: if (fire && seg_end) st_nxt = pos_r == total - 16'h0001 ? PTF_IDLE : PTF_HDR;
			default: st_nxt = PTF_IDLE;
		endcase
	end

	// ************************************************************
	// sequence state and output registers
	// ************************************************************
	wire [7:0] nxt_b = out_b;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r <= PTF_IDLE;
			pos_r <= 16'h0000;
			hidx_r <= 16'h0000;
			room_r <= 16'h0000;
			crc_r <= `PTF_CRC_INIT;
			mark_r <= 1'b0;
			seg_r <= 16'h0000;
			seq_pre_r <= 16'h0000;
			seq_tim_r <= 16'h0000;
			pkt_valid <= 1'b0;
			pkt_byte <= 8'h00;
			pkt_first <= 1'b0;
			pkt_last <= 1'b0;
			pkt_dst_addr <= 32'h00000000;
			pkt_dst_port <= 16'h0000;
		end else if (clk_en) begin
			st_r <= st_nxt;
			if (start) begin
				pos_r <= 16'h0000;
				hidx_r <= 16'h0000;
				crc_r <= `PTF_CRC_INIT;
				mark_r <= 1'b1;
				pkt_dst_addr <= `PTF_MCAST_ADDR;
				pkt_dst_port <= hwdata[`PTF_CTRL_TIMING] ? `PTF_PORT_TIMING : `PTF_PORT_PRE;
			end
			if (fire) begin
				if (st_r == PTF_HDR) begin
					hidx_r <= hidx_r + 16'h0001;
					room_r <= cap;
				end else begin
					pos_r <= pos_r + 16'h0001;
					room_r <= room_r - 16'h0001;
					if (st_r == PTF_BODY)
						crc_r <= crc_step(crc_r, out_b);
					if (seg_end) begin
						hidx_r <= 16'h0000;
						mark_r <= 1'b0;
						seg_r <= seg_r + 16'h0001;
						if (timing)
							seq_tim_r <= seq_tim_r + 16'h0001;
						else
							seq_pre_r <= seq_pre_r + 16'h0001;
					end
				end
			end
			// the last byte of a set still drains after state has gone idle
			if (!pkt_valid || pkt_ready) begin
				pkt_valid <= st_r != PTF_IDLE;
				pkt_byte <= nxt_b;
				pkt_first <= st_r == PTF_HDR && hidx_r == 16'h0000;
				pkt_last <= st_r != PTF_HDR && seg_end;
			end
		end
	end

	// ************************************************************
	// checks on what the framer drives
	// ************************************************************
	// one header byte moving from state into the output register
	sequence s_hdr_load(int unsigned n);
		fire && st_r == PTF_HDR && hidx_r == n;
	endsequence

	property p_read_wait;
		@(posedge hclk) disable iff (!hresetn)
		clk_en && take && !hwrite |=> !hreadyout;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read without wait state");

	property p_first_flags;
		@(posedge hclk) disable iff (!hresetn)
		s_hdr_load(`PTF_RTP_AT) |=> pkt_byte[7:6] == `PTF_RTP_VERSION && pkt_byte[3:0] == 4'h0
			&& pkt_byte[4] == $past(sign);
	endproperty
	a_first_flags: assert property (p_first_flags) else $error("rtp flag byte wrong");

	property p_timing_pad;
		@(posedge hclk) disable iff (!hresetn)
		s_hdr_load(`PTF_RTP_AT) |=> !$past(timing) || !pkt_byte[5];
	endproperty
	a_timing_pad: assert property (p_timing_pad) else $error("timing padding set");

	property p_marker;
		@(posedge hclk) disable iff (!hresetn)
		s_hdr_load(`PTF_RTP_AT + 1) |=> pkt_byte[7] == ($past(pos_r) == 16'h0000);
	endproperty
	a_marker: assert property (p_marker) else $error("marker wrong");

	property p_ptype;
		@(posedge hclk) disable iff (!hresetn)
		s_hdr_load(`PTF_RTP_AT + 1) |=> pkt_byte[6:0] == ($past(timing) ? `PTF_PT_TIMING : `PTF_PT_PRE);
	endproperty
	a_ptype: assert property (p_ptype) else $error("payload type wrong");

	property p_ts_high;
		@(posedge hclk) disable iff (!hresetn)
		s_hdr_load(`PTF_RTP_AT + 4) |=> pkt_byte == $past(sec_r[21:14]);
	endproperty
	a_ts_high: assert property (p_ts_high) else $error("timestamp seconds wrong");

	property p_ts_low;
		@(posedge hclk) disable iff (!hresetn)
		s_hdr_load(`PTF_RTP_AT + 7) |=> pkt_byte == $past(nano_r[27:20]);
	endproperty
	a_ts_low: assert property (p_ts_low) else $error("timestamp fraction wrong");

	property p_ssrc_zero;
		@(posedge hclk) disable iff (!hresetn)
		fire && st_r == PTF_HDR && hidx_r >= `PTF_RTP_AT + 16'h0008
			&& hidx_r < `PTF_RTP_AT + 16'h000c |=> pkt_byte == 8'h00;
	endproperty
	a_ssrc_zero: assert property (p_ssrc_zero) else $error("source id not zero");

	property p_len_high;
		@(posedge hclk) disable iff (!hresetn)
		fire && st_r == PTF_BODY && pos_r == 16'h0000 |=> pkt_byte == $past(len_r[15:8]);
	endproperty
	a_len_high: assert property (p_len_high) else $error("length byte wrong");

	property p_dest;
		@(posedge hclk) disable iff (!hresetn)
		busy |-> pkt_dst_addr == `PTF_MCAST_ADDR
			&& pkt_dst_port == (timing ? `PTF_PORT_TIMING : `PTF_PORT_PRE);
	endproperty
	a_dest: assert property (p_dest) else $error("destination wrong");

	property p_seq_pre;
		@(posedge hclk) disable iff (!hresetn)
		fire && st_r != PTF_HDR && seg_end && !timing |=> seq_pre_r == $past(seq_pre_r) + 16'h0001;
	endproperty
	a_seq_pre: assert property (p_seq_pre) else $error("preamble sequence step");

	property p_seq_tim;
		@(posedge hclk) disable iff (!hresetn)
		fire && st_r != PTF_HDR && seg_end && timing |=> seq_tim_r == $past(seq_tim_r) + 16'h0001;
	endproperty
	a_seq_tim: assert property (p_seq_tim) else $error("timing sequence step");

	property p_valid_hold;
		@(posedge hclk) disable iff (!hresetn)
		pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_byte) && $stable(pkt_last);
	endproperty
	a_valid_hold: assert property (p_valid_hold) else $error("byte dropped under stall");

	property p_set_end;
		@(posedge hclk) disable iff (!hresetn)
		fire && st_r == PTF_CRC && pos_r == total - 16'h0001 |=> pkt_last && st_r == PTF_IDLE;
	endproperty
	a_set_end: assert property (p_set_end) else $error("set not closed after check word");
endmodule // ptf_framer
`default_nettype wire

// ---- src/ptf_pkg.sv ----
// ptf_pkg.sv: types shared by the framer
// assumes ptf_defs.svh is compiled alongside
package ptf_pkg;
	typedef enum logic [1:0] {
		PTF_IDLE = 2'b00,
		PTF_HDR = 2'b01,
		PTF_BODY = 2'b10,
		PTF_CRC = 2'b11
	} ptf_state_e;
	typedef logic [31:0] ptf_word_t;
endpackage

// ---- verification/ptf_sink.sv ----
// ptf_sink.sv: far-end byte sink that keeps the latest packet of the framer
// assumes one clock domain shared with the framer
`timescale 1ns/1ps
`default_nettype none
module ptf_sink (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic [7:0] pkt_byte,
	input wire logic pkt_valid,
	input wire logic pkt_first,
	input wire logic pkt_last,
	output logic pkt_ready
);
	// ****
	// capture
	// ****
	logic [7:0] mem_r [0:127];
	int n_r;
	int pkts_r;
	logic [1:0] ph_r;
	// stall one cycle in four so the framer must hold its byte
	assign pkt_ready = (ph_r != 2'h3);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ph_r <= 2'h0;
			n_r <= 0;
			pkts_r <= 0;
		end else begin
			ph_r <= ph_r + 2'h1;
			if (pkt_valid && pkt_ready) begin
				mem_r[pkt_first ? 0 : n_r] <= pkt_byte;
				// a start byte throws away whatever was gathered
				n_r <= pkt_first ? 1 : n_r + 1;
				if (pkt_last)
					pkts_r <= pkts_r + 1;
			end
		end
	end
endmodule // ptf_sink
`default_nettype wire

// ---- verification/testbench.sv ----
// testbench.sv: drives the framer over ahb-lite and checks captured packets
// assumes ptf_sink as the far end and a 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, dst_a;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, pkt_valid, pkt_first, pkt_last, pkt_ready;
	logic [7:0] pkt_byte;
	logic [15:0] dst_p;
	int num_errors = 0, n_compared = 0;
	localparam logic [31:0] SEC = 32'h12345678, NS = 32'h1fedcba9;
	always #10 hclk = ~hclk;
	ptf_framer #(.MAX_BYTES(64)) i_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .pkt_byte(pkt_byte), .pkt_valid(pkt_valid), .pkt_first(pkt_first),
		.pkt_last(pkt_last), .pkt_ready(pkt_ready), .pkt_dst_addr(dst_a), .pkt_dst_port(dst_p));
	ptf_sink i_sink (.hclk(hclk), .hresetn(hresetn), .pkt_byte(pkt_byte),
		.pkt_valid(pkt_valid), .pkt_first(pkt_first), .pkt_last(pkt_last),
		.pkt_ready(pkt_ready));
	// ****
	// tasks
	// ****
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(logic w, logic [31:0] a, logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	function automatic logic [15:0] crc(logic [47:0] m);
		logic [15:0] c;
		c = 16'hffff;
		for (int i = 47; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? 16'h1021 : 16'h0);
		return c;
	endfunction
	task automatic send(logic [3:0] ctl, logic [6:0] pt, logic [7:0] b0, logic [15:0] port,
		output logic [15:0] sq);
		logic [31:0] q;
		int h;
		int k;
		h = ctl[2] ? 48 : 40;
		do bus(1'b0, 32'h14, 32'h0, q); while (q !== 32'h0);
		k = i_sink.pkts_r;
		bus(1'b1, 32'h4, SEC, q);
		bus(1'b1, 32'h8, NS, q);
		bus(1'b1, 32'hc, 32'h4, q);
		for (int i = 0; i < 4; i++)
			bus(1'b1, 32'h1c, 32'ha0 + i, q);
		bus(1'b1, 32'h0, {28'h0, ctl}, q);
		for (int t = 0; t < 3000 && i_sink.pkts_r == k; t++)
			@(posedge hclk);
		chk("pkt count", k + 1, i_sink.pkts_r);
		chk("flags", b0, i_sink.mem_r[28]);
		chk("marker pt", {1'b1, pt}, i_sink.mem_r[29]);
		chk("timestamp", {SEC[21:0], NS[29:20]}, {i_sink.mem_r[32], i_sink.mem_r[33],
			i_sink.mem_r[34], i_sink.mem_r[35]});
		chk("ssrc", 0, {i_sink.mem_r[36], i_sink.mem_r[37], i_sink.mem_r[38],
			i_sink.mem_r[39]});
		chk("dst addr", 32'hef003330, dst_a);
		chk("dst port", port, dst_p);
		chk("length", 4, {i_sink.mem_r[h], i_sink.mem_r[h + 1]});
		chk("data", 8'ha3, i_sink.mem_r[h + 5]);
		chk("check word", crc({16'h4, 32'ha0a1a2a3}), {i_sink.mem_r[h + 6],
			i_sink.mem_r[h + 7]});
		sq = {i_sink.mem_r[30], i_sink.mem_r[31]};
		$display("test ctrl %h done", ctl);
	endtask
	// a short mtu pushes the four data bytes into two packets of one set
	task automatic send_split();
		logic [31:0] q, ts;
		logic [15:0] sq;
		int k;
		do bus(1'b0, 32'h14, 32'h0, q); while (q !== 32'h0);
		bus(1'b1, 32'h10, 32'd44, q);
		k = i_sink.pkts_r;
		for (int i = 0; i < 4; i++)
			bus(1'b1, 32'h1c, 32'ha0 + i, q);
		bus(1'b1, 32'h0, 32'h1, q);
		for (int t = 0; t < 3000 && i_sink.pkts_r == k; t++)
			@(posedge hclk);
		ts = {i_sink.mem_r[32], i_sink.mem_r[33], i_sink.mem_r[34], i_sink.mem_r[35]};
		sq = {i_sink.mem_r[30], i_sink.mem_r[31]};
		chk("split first marker", {1'b1, 7'h4d}, i_sink.mem_r[29]);
		chk("split first data", 8'ha1, i_sink.mem_r[43]);
		for (int t = 0; t < 3000 && i_sink.pkts_r == k + 1; t++)
			@(posedge hclk);
		chk("split pkt count", k + 2, i_sink.pkts_r);
		chk("split next marker", {1'b0, 7'h4d}, i_sink.mem_r[29]);
		chk("split timestamp", ts, {i_sink.mem_r[32], i_sink.mem_r[33], i_sink.mem_r[34],
			i_sink.mem_r[35]});
		chk("split seq", sq + 16'h1, {i_sink.mem_r[30], i_sink.mem_r[31]});
		chk("split data", 16'ha2a3, {i_sink.mem_r[40], i_sink.mem_r[41]});
		chk("split check word", crc({16'h4, 32'ha0a1a2a3}), {i_sink.mem_r[42],
			i_sink.mem_r[43]});
		do bus(1'b0, 32'h14, 32'h0, q); while (q !== 32'h0);
		bus(1'b1, 32'h10, 32'h5dc, q);
		bus(1'b0, 32'h10, 32'h0, q);
		chk("mtu restore", 32'h5dc, q);
		$display("test split done");
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// ****
	// sequence
	// ****
	initial begin
		logic [31:0] q;
		logic [15:0] s0, s1;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(1'b0, 32'h10, 32'h0, q);
		chk("mtu reset", 32'h5dc, q);
		bus(1'b0, 32'h40, 32'h0, q);
		chk("unmapped", 0, q);
		chk("hresp", 0, hresp);
		send(4'h1, 7'h4d, 8'h80, 16'd30064, s0);
		send(4'h1, 7'h4d, 8'h80, 16'd30064, s1);
		chk("pre seq", s0 + 16'h1, s1);
		// padding request must not reach a timing packet
		send(4'hb, 7'h4c, 8'h80, 16'd30065, s0);
		send(4'h7, 7'h4c, 8'h90, 16'd30065, s1);
		chk("timing seq", s0 + 16'h1, s1);
		send_split();
		stop_test();
	end
	initial begin
		#1000000;
		num_errors++;
		stop_test();
	end
endmodule // testbench
`default_nettype wire
